// [common/hrw_regs.vh]
// Register offsets, field positions, reset values and timing for the hibernation RTC block
`ifndef HRW_REGS_VH
`define HRW_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define HRW_OFF_RTC_CTL   6'h00
`define HRW_OFF_SECONDS   6'h04
`define HRW_OFF_SUBSEC    6'h08
`define HRW_OFF_MATCH_SEC 6'h0c
`define HRW_OFF_MATCH_SUB 6'h10
`define HRW_OFF_TRIM      6'h14
`define HRW_OFF_WAKE_CFG  6'h18
`define HRW_OFF_BATT_CFG  6'h1c
`define HRW_OFF_HIB_CTL   6'h20
`define HRW_OFF_RAW_STAT  6'h24
`define HRW_OFF_INT_MASK  6'h28
`define HRW_OFF_MASK_STAT 6'h2c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HRW_WAKE_PIN  0
`define HRW_WAKE_RTC  1
`define HRW_WAKE_BATT 2
`define HRW_BATT_DETECT 0
`define HRW_BATT_ABORT  1
`define HRW_BATT_THR_LO 2
`define HRW_BATT_THR_HI 3
`define HRW_ST_WR_DONE  0
`define HRW_ST_PIN_WAKE 1
`define HRW_ST_BATT_LOW 2
`define HRW_ST_RTC_MATCH 3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define HRW_TRIM_NOMINAL 16'h7fff
`define HRW_MATCH_SEC_RST 32'hffffffff
`define HRW_TRIM_PERIOD_S 64
`define HRW_TRIM_SLOT 6'h3f
`define HRW_SUBSEC_W 16

`endif

// [core/hrw_top.v]
// Hibernation controller: RTC with prescaler trim, matches, battery-low and wake logic
//
// Implementation choices: the register addresses and register access over APB.
`default_nettype none
`include "hrw_regs.vh"

// Summary of operation
// - Enabled battery-low below threshold sets raw status
// - Abort mode refuses hibernation while battery low
// - Two-bit threshold picks one of four levels
// - Hibernation request drops regulator enable
// - Any enabled wake source restores regulator enable
// - State survives processor reset; own reset only
// - RTC enable gates counter, match and wake
// - Readable 32-bit seconds counter
// - Seconds writable when enabled; counts real seconds
// - Readable sub-second count in timebase ticks
// - Only match index zero exists
// - Seconds match flags event for wake/interrupt
// - Match needs seconds and sub-second equality
// - Prescaler divides timebase into one-second tick
// - Trim value used once every 64 seconds
// - Trim resets to nominal, readable back
// - Three independent wake source enables
// - Wake enables read back as written
// - Battery mode and threshold read back
// - Raw and masked status both readable
module hrw_top (
  input wire sys_clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire lf_tick,
  input wire wake_pin,
  input wire [3:0] batt_below,
  output reg regulator_en,
  output reg hibernating
);

  // ----------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------
  localparam ST_RUN = 1'b0;
  localparam ST_HIB = 1'b1;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg rtc_en;
  reg [31:0] seconds;
  reg [`HRW_SUBSEC_W-1:0] subsec;
  reg [31:0] match_sec;
  reg [`HRW_SUBSEC_W-1:0] match_sub;
  reg [`HRW_SUBSEC_W-1:0] trim;
  reg [5:0] trim_cnt;
  reg [2:0] wake_cfg;
  reg batt_low_detect_only;
  reg batt_low_abort_sleep;
  reg [1:0] batt_thresh;
  reg [3:0] raw_stat;
  reg [3:0] int_mask;
  reg state;
  reg refused;

  wire acc = psel & penable & pready;
  // A refused write must not land on an aliased register
  wire wr_en = acc & pwrite & ~pslverr;
  wire [5:0] off = paddr[5:0];

  function is_wr;
    input [5:0] a;
    input [5:0] o;
    begin
      is_wr = (a == o);
    end
  endfunction

  // ----------------------------------------------------------------
  // Write strobes, one per writable register
  // ----------------------------------------------------------------
  // Strobes fire only in the completing access cycle
  wire wr_rtc_ctl = wr_en & is_wr(off, `HRW_OFF_RTC_CTL);
  wire wr_seconds = wr_en & is_wr(off, `HRW_OFF_SECONDS);
  wire wr_match_sec = wr_en & is_wr(off, `HRW_OFF_MATCH_SEC);
  wire wr_match_sub = wr_en & is_wr(off, `HRW_OFF_MATCH_SUB);
  wire wr_trim = wr_en & is_wr(off, `HRW_OFF_TRIM);
  wire wr_wake_cfg = wr_en & is_wr(off, `HRW_OFF_WAKE_CFG);
  wire wr_batt_cfg = wr_en & is_wr(off, `HRW_OFF_BATT_CFG);
  wire wr_hib_ctl = wr_en & is_wr(off, `HRW_OFF_HIB_CTL);
  wire wr_raw_stat = wr_en & is_wr(off, `HRW_OFF_RAW_STAT);
  wire wr_int_mask = wr_en & is_wr(off, `HRW_OFF_INT_MASK);

  // ----------------------------------------------------------------
  // Timebase, prescaler and matches
  // ----------------------------------------------------------------
  // Trim applies only in the last second of each 64-second window
  wire use_trim = (trim_cnt == `HRW_TRIM_SLOT);
  wire [`HRW_SUBSEC_W-1:0] divisor = use_trim ? trim : `HRW_TRIM_NOMINAL;
  wire term = rtc_en & lf_tick & (subsec == divisor);
  wire sec_wr = wr_seconds & rtc_en;
  wire match_hit = rtc_en & (seconds == match_sec) & (subsec == match_sub);

  // A new time restarts the second from zero, so the write beats a tick
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      subsec <= 16'h0000;
    end else if (sec_wr | term) begin
      subsec <= 16'h0000;
    end else if (rtc_en & lf_tick) begin
      subsec <= subsec + 16'h0001;
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      seconds <= 32'h00000000;
    end else if (sec_wr) begin
      seconds <= pwdata;
    end else if (term) begin
      seconds <= seconds + 32'h00000001;
    end
  end

  // Elapsed seconds mod 64, counted apart from the seconds register and held across its writes, place the trimmed second
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      trim_cnt <= 6'h00;
    end else if (term & ~sec_wr) begin
      trim_cnt <= trim_cnt + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Battery monitor
  // ----------------------------------------------------------------
  // Comparator outputs arrive already settled, one per trip level
  wire batt_mon_on = batt_low_detect_only | batt_low_abort_sleep;
  wire batt_low = batt_mon_on & batt_below[batt_thresh];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // One process per register: a strobe can only ever touch its own word
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rtc_en <= 1'b0;
    end else if (wr_rtc_ctl) begin
      rtc_en <= pwdata[0];
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      match_sec <= `HRW_MATCH_SEC_RST;
    end else if (wr_match_sec) begin
      match_sec <= pwdata;
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      match_sub <= 16'h0000;
    end else if (wr_match_sub) begin
      match_sub <= pwdata[15:0];
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      trim <= `HRW_TRIM_NOMINAL;
    end else if (wr_trim) begin
      trim <= pwdata[15:0];
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake_cfg <= 3'h0;
    end else if (wr_wake_cfg) begin
      wake_cfg <= pwdata[2:0];
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      batt_low_detect_only <= 1'b0;
      batt_low_abort_sleep <= 1'b0;
      batt_thresh <= 2'h0;
    end else if (wr_batt_cfg) begin
      batt_low_detect_only <= pwdata[`HRW_BATT_DETECT];
      batt_low_abort_sleep <= pwdata[`HRW_BATT_ABORT];
      batt_thresh <= pwdata[`HRW_BATT_THR_HI:`HRW_BATT_THR_LO];
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      int_mask <= 4'h0;
    end else if (wr_int_mask) begin
      int_mask <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Raw status: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  wire pin_evt = (state == ST_HIB) & wake_cfg[`HRW_WAKE_PIN] & wake_pin;
  wire [3:0] set_vec = {match_hit, batt_low, pin_evt, wr_en};
  wire [3:0] clr_vec = wr_raw_stat ? pwdata[3:0] : 4'h0;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      raw_stat <= 4'h0;
    else
      raw_stat <= (raw_stat & ~clr_vec) | set_vec;
  end

  // ----------------------------------------------------------------
  // Hibernation sequencer
  // ----------------------------------------------------------------
  // Only the block's own reset clears this; processor resets never reach it
  wire hib_req = wr_hib_ctl & pwdata[0];
  wire wake_any = (wake_cfg[`HRW_WAKE_PIN] & wake_pin) |
                  (wake_cfg[`HRW_WAKE_RTC] & match_hit) |
                  (wake_cfg[`HRW_WAKE_BATT] & batt_low);
  reg next_state;
  reg next_refused;

  always @* begin
    next_state = state;
    next_refused = refused;
    case (state)
      ST_RUN: begin
        if (hib_req) begin
          if (batt_low_abort_sleep & batt_low) begin
            next_refused = 1'b1;
          end else begin
            next_refused = 1'b0;
            next_state = ST_HIB;
          end
        end
      end
      ST_HIB: begin
        if (wake_any)
          next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_RUN;
      refused <= 1'b0;
    end else begin
      state <= next_state;
      refused <= next_refused;
    end
  end

  // Regulator stays on through reset so a cold start always powers up
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regulator_en <= 1'b1;
    end else begin
      regulator_en <= (next_state == ST_RUN);
    end
  end

  // Same edge as the regulator, so the two never disagree
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hibernating <= 1'b0;
    end else begin
      hibernating <= (next_state == ST_HIB);
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, registered answer
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;
  reg rd_hit;

  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (off)
      `HRW_OFF_RTC_CTL: rd_mux = {31'h0, rtc_en};
      `HRW_OFF_SECONDS: rd_mux = seconds;
      `HRW_OFF_SUBSEC: rd_mux = {16'h0, subsec};
      `HRW_OFF_MATCH_SEC: rd_mux = match_sec;
      `HRW_OFF_MATCH_SUB: rd_mux = {16'h0, match_sub};
      `HRW_OFF_TRIM: rd_mux = {16'h0, trim};
      `HRW_OFF_WAKE_CFG: rd_mux = {29'h0, wake_cfg};
      `HRW_OFF_BATT_CFG: rd_mux = {28'h0, batt_thresh, batt_low_abort_sleep,
                                   batt_low_detect_only};
      `HRW_OFF_HIB_CTL: rd_mux = {30'h0, refused, state};
      `HRW_OFF_RAW_STAT: rd_mux = {28'h0, raw_stat};
      `HRW_OFF_INT_MASK: rd_mux = {28'h0, int_mask};
      `HRW_OFF_MASK_STAT: rd_mux = {28'h0, raw_stat & int_mask};
      default: rd_hit = 1'b0;
    endcase
  end

  // Refused when the offset is unmapped or any upper address bit is set
  wire addr_bad = ~rd_hit | (paddr[31:6] != 26'h0);
  wire first_acc = psel & penable & ~pready;

  // Ready rises in the second access cycle, so each transfer takes three edges
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      pready <= first_acc;
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= first_acc & addr_bad;
    end
  end

  // A refused read returns zero rather than an aliased register
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (first_acc & ~pwrite) begin
      prdata <= addr_bad ? 32'h00000000 : rd_mux;
    end
  end

endmodule
`default_nettype wire

// [sim/hibernation_rtc_wake_tb.sv]
// Self-checking bench for the hibernation RTC block
`default_nettype none
`include "hrw_regs.vh"
module hibernation_rtc_wake_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic lf_tick = 1'b0, press = 1'b0, pready, pslverr, wake_pin, regulator_en, hibernating, cpu_on;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, s;
  logic [3:0] batt_below = 4'h0;
  logic [64:0] q[$];
  logic [64:0] e;
  int err_total = 0, checks = 0;
  hrw_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lf_tick(lf_tick), .wake_pin(wake_pin), .batt_below(batt_below),
    .regulator_en(regulator_en), .hibernating(hibernating));
  hrw_pwr_model i_pwr (.sys_clk(sys_clk), .regulator_en(regulator_en), .press(press),
    .wake_pin(wake_pin), .cpu_on(cpu_on));
  // ----
  // Tasks
  // ----
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x, input logic [31:0] m);
    checks++;
    if ((g & m) !== (x & m)) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask
  // Only offsets above the last status word are expected to be refused
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d,
    input logic [31:0] x, input logic [31:0] m);
    int n;
    q.push_back({a > 6'h2c, x, m});
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {26'h0, a};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge sys_clk);
    if (n == 20) begin
      err_total++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_reg(input logic v);
    int n;
    for (n = 0; n < 8 && regulator_en !== v; n++) @(posedge sys_clk);
    cmp({31'h0, regulator_en}, {31'h0, v}, 32'h1);
    cmp({31'h0, hibernating}, {31'h0, ~v}, 32'h1);
    if (n == 8) report_and_stop();
    @(posedge sys_clk);
    cmp({31'h0, cpu_on}, {31'h0, v}, 32'h1);
  endtask
  task automatic ticks(input int n);
    lf_tick <= 1'b1;
    repeat (n) @(posedge sys_clk);
    lf_tick <= 1'b0;
  endtask
  always @(posedge sys_clk) begin
    if (pready === 1'b1 && q.size() == 0) begin
      err_total++;
      $display("CHECK FAILED %0t ready with no request", $time);
    end else if (pready === 1'b1) begin
      e = q.pop_front();
      cmp({31'h0, pslverr}, {31'h0, e[64]}, 32'h1);
      cmp(prdata, e[63:32], e[31:0]);
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    s = $urandom(32'h00906f3d);
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(0, `HRW_OFF_TRIM, 0, 32'h7fff, 32'hffff);
    apb(0, `HRW_OFF_MATCH_SEC, 0, 32'hffffffff, 32'hffffffff);
    apb(0, 6'h30, 0, 0, 0);
    apb(1, 6'h3c, 0, 0, 0);
    s = $urandom;
    apb(1, `HRW_OFF_WAKE_CFG, s, 0, 0);
    apb(0, `HRW_OFF_WAKE_CFG, 0, s, 32'h7);
    apb(1, `HRW_OFF_TRIM, s, 0, 0);
    apb(0, `HRW_OFF_TRIM, 0, s, 32'hffff);
    for (int k = 0; k < 4; k++) begin
      apb(1, `HRW_OFF_BATT_CFG, 32'(k * 4 + 1), 0, 0);
      apb(0, `HRW_OFF_BATT_CFG, 0, 32'(k * 4 + 1), 32'hf);
      batt_below <= 4'hf ^ (4'h1 << k);
      apb(1, `HRW_OFF_RAW_STAT, 32'hf, 0, 0);
      apb(0, `HRW_OFF_RAW_STAT, 0, 32'h1, 32'h7);
      batt_below <= 4'h1 << k;
      apb(0, `HRW_OFF_RAW_STAT, 0, 32'h5, 32'h7);
    end
    apb(1, `HRW_OFF_BATT_CFG, 32'h6, 0, 0);
    batt_below <= 4'h2;
    apb(1, `HRW_OFF_WAKE_CFG, 32'h1, 0, 0);
    apb(1, `HRW_OFF_HIB_CTL, 32'h1, 0, 0);
    repeat (3) @(posedge sys_clk);
    cmp({31'h0, regulator_en}, 32'h1, 32'h1);
    apb(0, `HRW_OFF_HIB_CTL, 0, 32'h2, 32'h3);
    batt_below <= 4'h1;
    apb(1, `HRW_OFF_HIB_CTL, 32'h1, 0, 0);
    wait_reg(1'b0);
    press <= 1'b1;
    wait_reg(1'b1);
    press <= 1'b0;
    apb(0, `HRW_OFF_RAW_STAT, 0, 32'h2, 32'h2);
    ticks(10);
    apb(0, `HRW_OFF_SUBSEC, 0, 0, 32'hffff);
    apb(1, `HRW_OFF_SECONDS, s, 0, 0);
    apb(0, `HRW_OFF_SECONDS, 0, 0, 32'hffffffff);
    apb(1, `HRW_OFF_RTC_CTL, 32'h1, 0, 0);
    ticks(7);
    apb(0, `HRW_OFF_SUBSEC, 0, 32'h7, 32'hffff);
    apb(1, `HRW_OFF_SECONDS, s, 0, 0);
    apb(0, `HRW_OFF_SUBSEC, 0, 0, 32'hffff);
    apb(1, `HRW_OFF_MATCH_SEC, s + 1, 0, 0);
    apb(1, `HRW_OFF_MATCH_SUB, 32'h5, 0, 0);
    apb(1, `HRW_OFF_WAKE_CFG, 32'h2, 0, 0);
    apb(1, `HRW_OFF_HIB_CTL, 32'h1, 0, 0);
    wait_reg(1'b0);
    ticks(32772);
    cmp({31'h0, regulator_en}, 32'h0, 32'h1);
    ticks(1);
    wait_reg(1'b1);
    apb(0, `HRW_OFF_SECONDS, 0, s + 1, 32'hffffffff);
    apb(1, `HRW_OFF_INT_MASK, 32'h8, 0, 0);
    apb(0, `HRW_OFF_MASK_STAT, 0, 32'h8, 32'hf);
    report_and_stop();
  end
endmodule
`default_nettype wire

// [sim/hrw_props.sv]
// Port checker for the hibernation RTC block
`default_nettype none
module hrw_props (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic regulator_en,
  input wire logic hibernating
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----
  // Assertions
  // ----
  rdy_one_cycle_a: assert property (pready |=> !pready) else $error("long ready");
  wait_state_a: assert property (psel && penable && !pready |=> pready) else $error("no ready");
  rdy_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
  sleep_entry_a: assert property ($fell(regulator_en) |-> $rose(hibernating))
    else $error("regulator drop without sleep");
  entry_cause_a: assert property ($rose(hibernating) |-> $past(pready && pwrite)
    || $past(pready && pwrite, 2)) else $error("sleep without write");
  wake_cause_a: assert property ($rose(regulator_en) |-> $past(hibernating))
    else $error("wake while awake");
  cover property ($rose(hibernating));
  cover property ($rose(regulator_en));
  cover property (pslverr);
endmodule
bind hrw_top hrw_props i_props (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .regulator_en(regulator_en), .hibernating(hibernating));
`default_nettype wire

// [sim/hrw_pwr_model.sv]
// Model of the external regulator and the wake button
`default_nettype none
module hrw_pwr_model (
  input wire logic sys_clk,
  input wire logic regulator_en,
  input wire logic press,
  output logic wake_pin = 1'b0,
  output logic cpu_on = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Button is synchronised outside, so the pin lags one edge
  always @(posedge sys_clk) begin
    wake_pin <= press;
    cpu_on <= regulator_en;
  end
endmodule
`default_nettype wire
